// file: pkg/usbgc_pkg.sv
// Purpose: Constants and types shared by the USB global control register block.
// Assumes: 100 MHz controller clock, 8-bit special-function register space.
// Notes:   Bit positions follow the register layout; all bits reset to zero.
package usbgc_pkg;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [7:0] USBGC_CTRL_ADDR    = 8'hBC;
  localparam logic [7:0] USBGC_CTRL_RESET   = 8'h00;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int USBGC_BIT_ENABLE   = 7;
  localparam int USBGC_BIT_SUSPEND_CLOCK_GATE  = 6;
  localparam int USBGC_BIT_WAKE     = 5;
  localparam int USBGC_BIT_DETACH   = 4;
  localparam int USBGC_BIT_UPRES    = 3;
  localparam int USBGC_BIT_PERMIT   = 2;
  localparam int USBGC_BIT_CONFIG   = 1;
  localparam int USBGC_BIT_ADDRV    = 0;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int USBGC_CLK_MHZ         = 100;
  localparam int USBGC_SUSPEND_MIN_US  = 5000;
  localparam int USBGC_SUSPEND_CYCLES  = USBGC_SUSPEND_MIN_US * USBGC_CLK_MHZ;
  localparam int USBGC_CNT_W           = 20;

  // ---------------------------------------------------------------------------
  // Upstream resume sequencer
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    USBGC_ST_IDLE = 3'b001,
    USBGC_ST_WAIT = 3'b010,
    USBGC_ST_SEND = 3'b100
  } usbgc_state_t;

endpackage

// file: pkg/usbgc_susp_if.sv
// Purpose: Carries the suspend timer's request and status between modules.
// Assumes: Single clock domain.
// Notes:   The control block clears and runs the timer; the timer reports.
`timescale 1ns/1ns
interface usbgc_susp_if;
  logic run;
  logic long_enough;
  modport ctrl  (output run, input long_enough);
  modport timer (input run, output long_enough);
endinterface

// file: rtl/usbgc_ctrl.sv
// Purpose: USB global control register and its hardware side effects.
// Assumes: Firmware accesses the register over the SFR strobes below.
// Notes:   Bus-side inputs are synchronised; the pull-up output is tri-state.
//
// Contract
// - Enable clear resets controller, stops clocks.
// - Wake bit raises wake request to controller.
// - Resume needs permit, clocks, 5 ms suspend.
// - Detach bit floats pull-up; clear drives high.
// - Resume status set by wake while permitted.
// - Resume status cleared when signalling ends.
// - Configured cleared by reset and bus reset.
// - Address valid cleared by resets; default address.
// - Detach holds pull-up in high impedance.
`timescale 1ns/1ns
module usbgc_ctrl
  import usbgc_pkg::*;
#(
  parameter int SUSPEND_CYCLES = USBGC_SUSPEND_CYCLES
) (
  input  wire logic       clk,             // Controller clock, 100 MHz
  input  wire logic       resetn,          // Synchronous reset, active low
  input  wire logic [7:0] sfr_addr,        // Register address
  input  wire logic       sfr_wr,          // Write strobe
  input  wire logic       sfr_rd,          // Read strobe
  input  wire logic [7:0] sfr_wdata,       // Write data
  output logic      [7:0] sfr_rdata,       // Registered read data
  input  wire logic       bus_reset_in,    // Bus reset detected, from line logic
  input  wire logic       bus_suspend_in,  // Bus is in suspend state
  input  wire logic       resume_done_in,  // Upstream resume signalling finished
  output logic            ctrl_reset_n,    // Controller reset, active low
  output logic            ctrl_clk_en,     // Controller clock enable
  output logic            wake_request,    // Wake request to controller
  output logic            resume_send,     // Transmit upstream resume now
  output logic            use_default_addr,// Respond at function address 0
  output logic            pullup_out,      // Pull-up supply drive value
  output logic            pullup_oe        // Pull-up supply drive enable
);

  // ---------------------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------------------
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
    end else begin
      sync1_q <= {resume_done_in, bus_suspend_in, bus_reset_in};
      sync2_q <= sync1_q;
    end
  end

  logic bus_reset;
  logic bus_suspend;
  logic resume_done;
  assign bus_reset   = sync2_q[0];
  assign bus_suspend = sync2_q[1];
  assign resume_done = sync2_q[2];

  // ---------------------------------------------------------------------------
  // Suspend duration timer
  // ---------------------------------------------------------------------------
  usbgc_susp_if sif ();

  usbgc_susp_timer #(
    .SUSPEND_CYCLES (SUSPEND_CYCLES)
  ) u_timer (
    .clk    (clk),
    .resetn (resetn),
    .sif    (sif)
  );

  // ---------------------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------------------
  logic [7:0]   reg_q;
  logic [7:0]   reg_d;
  logic [7:0]   rdata_q;
  logic [7:0]   rdata_d;
  usbgc_state_t st_q;
  usbgc_state_t st_d;
  logic         wr_hit;
  logic         clocks_on;

  assign wr_hit    = sfr_wr && (sfr_addr == USBGC_CTRL_ADDR);
  assign clocks_on = reg_q[USBGC_BIT_ENABLE] && !reg_q[USBGC_BIT_SUSPEND_CLOCK_GATE];

  // The timer only runs while the controller can see the bus.
  assign sif.run = bus_suspend && reg_q[USBGC_BIT_ENABLE];

  always_comb begin
    reg_d   = reg_q;
    rdata_d = rdata_q;
    st_d    = st_q;
    if (wr_hit) begin
      // Hardware owns the resume status bit, so its lane is kept.
      reg_d = (sfr_wdata & ~(8'h01 << USBGC_BIT_UPRES))
            | (reg_q & (8'h01 << USBGC_BIT_UPRES));
    end
    case (st_q)
      USBGC_ST_IDLE: begin
        if (reg_q[USBGC_BIT_WAKE] && reg_q[USBGC_BIT_PERMIT]) begin
          reg_d[USBGC_BIT_UPRES] = 1'b1;
          st_d                   = USBGC_ST_WAIT;
        end
      end
      USBGC_ST_WAIT: begin
        // Resume leaves the line only once every condition holds.
        if (reg_q[USBGC_BIT_PERMIT] && clocks_on && sif.long_enough) begin
          st_d = USBGC_ST_SEND;
        end
      end
      USBGC_ST_SEND: begin
        if (resume_done) begin
          reg_d[USBGC_BIT_UPRES] = 1'b0;
        end
        // A wake bit still set after a resume must not start a second one,
        // so the sequencer parks here until firmware drops it.
        if ((resume_done || !reg_q[USBGC_BIT_UPRES]) && !reg_q[USBGC_BIT_WAKE]) begin
          st_d = USBGC_ST_IDLE;
        end
      end
      default: begin
        st_d = USBGC_ST_IDLE;
      end
    endcase
    if (bus_reset) begin
      reg_d[USBGC_BIT_CONFIG] = 1'b0;
      reg_d[USBGC_BIT_ADDRV]  = 1'b0;
    end
    if (!reg_q[USBGC_BIT_ENABLE]) begin
      reg_d[USBGC_BIT_UPRES] = 1'b0;
      st_d                   = USBGC_ST_IDLE;
    end
    if (sfr_rd && sfr_addr == USBGC_CTRL_ADDR) begin
      rdata_d = reg_q;
    end else if (sfr_rd) begin
      rdata_d = 8'h00;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      reg_q   <= USBGC_CTRL_RESET;
      rdata_q <= 8'h00;
      st_q    <= USBGC_ST_IDLE;
    end else begin
      reg_q   <= reg_d;
      rdata_q <= rdata_d;
      st_q    <= st_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign sfr_rdata        = rdata_q;
  assign ctrl_reset_n     = reg_q[USBGC_BIT_ENABLE];
  assign ctrl_clk_en      = clocks_on;
  assign wake_request     = reg_q[USBGC_BIT_WAKE];
  assign resume_send      = (st_q == USBGC_ST_SEND) && !resume_done
                          && reg_q[USBGC_BIT_UPRES];
  assign use_default_addr = !reg_q[USBGC_BIT_ADDRV];
  assign pullup_out       = 1'b1;
  assign pullup_oe        = !reg_q[USBGC_BIT_DETACH];

endmodule // usbgc_ctrl

// file: rtl/usbgc_susp_timer.sv
// Purpose: Measures how long the bus has been suspended.
// Assumes: run is synchronous to clk.
// Notes:   Saturates once the minimum suspend time has elapsed.
`timescale 1ns/1ns
module usbgc_susp_timer
  import usbgc_pkg::*;
#(
  parameter int SUSPEND_CYCLES = USBGC_SUSPEND_CYCLES
) (
  input  wire logic   clk,     // Controller clock
  input  wire logic   resetn,  // Synchronous reset, active low
  usbgc_susp_if.timer sif      // Run request and elapsed flag
);

  logic [USBGC_CNT_W-1:0] cnt_q;
  logic [USBGC_CNT_W-1:0] cnt_d;
  logic                   done_q;
  logic                   done_d;

  always_comb begin
    cnt_d  = cnt_q;
    done_d = done_q;
    if (!sif.run) begin
      cnt_d  = '0;
      done_d = 1'b0;
    end else if (cnt_q >= USBGC_CNT_W'(SUSPEND_CYCLES - 1)) begin
      done_d = 1'b1;
    end else begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      cnt_q  <= '0;
      done_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      done_q <= done_d;
    end
  end

  assign sif.long_enough = done_q;

endmodule // usbgc_susp_timer

// file: verif/testbench.sv
// Purpose: Self-checking bench for the USB global control register.
// Assumes: Short suspend timer; inputs change on the falling edge.
// Notes:   Rows cover plain writes; bus reset and resume follow by hand.
`timescale 1ns/1ns
module testbench;
  import usbgc_pkg::*;
  logic        clk = 0, resetn = 0, sfr_wr = 0, sfr_rd = 0, brst = 0, susp = 0;
  logic [7:0]  sfr_addr = 8'hBC, sfr_wdata = 8'h00, sfr_rdata, d;
  logic [3:0]  dly = 4'h1;
  logic        done, rst_n, clk_en, wake, send, dflt, pu, oe;
  int          error_cnt = 0, total_checks = 0;
  // Address valid is only set in the last two rows; a firmware write with bit 0 clear clears it again.
  logic [15:0] rows [8] = '{16'h8080, 16'hC0C0, 16'h9090, 16'h8E86,
                            16'h2020, 16'h0000, 16'hDFD7, 16'h7B73};
  usbgc_ctrl #(.SUSPEND_CYCLES(20)) dut (.clk(clk), .resetn(resetn), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .bus_reset_in(brst), .bus_suspend_in(susp), .resume_done_in(done),
    .ctrl_reset_n(rst_n), .ctrl_clk_en(clk_en), .wake_request(wake), .resume_send(send),
    .use_default_addr(dflt), .pullup_out(pu), .pullup_oe(oe));
  usbgc_line_model far (.clk(clk), .dly(dly), .resume_send(send), .resume_done_in(done));
  initial forever #5 clk = ~clk;
  task automatic chk(string n, logic [7:0] s, logic [7:0] e);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] v);
    @(negedge clk);
    sfr_addr = a;
    sfr_wdata = v;
    sfr_wr = 1;
    @(negedge clk);
    sfr_wr = 0;
  endtask
  task automatic rd(logic [7:0] a, output logic [7:0] v);
    @(negedge clk);
    sfr_addr = a;
    sfr_rd = 1;
    @(negedge clk);
    sfr_rd = 0;
    @(negedge clk);
    v = sfr_rdata;
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk);
    error_cnt++;
    close_out;
  end
  initial begin
    repeat (3) @(negedge clk);
    resetn = 1;
    rd(USBGC_CTRL_ADDR, d);
    chk("reset", d, USBGC_CTRL_RESET);
    chk("reset_outs", {3'h0, rst_n, clk_en, send, dflt, oe}, 8'h03);
    foreach (rows[i]) begin
      d = rows[i][15:8];
      wr(USBGC_CTRL_ADDR, d);
      chk("outs", {2'h0, pu, rst_n, clk_en, wake, oe, dflt},
          {2'h0, 1'b1, d[7], d[7] & ~d[6], d[5], ~d[4], ~d[0]});
      rd(USBGC_CTRL_ADDR, d);
      chk("readback", d, rows[i][7:0]);
    end
    wr(8'hBD, 8'hFF);
    rd(USBGC_CTRL_ADDR, d);
    chk("unmapped_wr", d, 8'h73);
    rd(8'hBD, d);
    chk("unmapped_rd", d, 8'h00);
    @(negedge clk);
    resetn = 0;
    repeat (3) @(negedge clk);
    resetn = 1;
    rd(USBGC_CTRL_ADDR, d);
    chk("mid_reset", d, USBGC_CTRL_RESET);
    chk("mid_reset_dflt", {7'h0, dflt}, 8'h01);
    wr(USBGC_CTRL_ADDR, 8'h83);
    brst = 1;
    repeat (4) @(negedge clk);
    wr(USBGC_CTRL_ADDR, 8'h83);
    brst = 0;
    repeat (3) @(negedge clk);
    rd(USBGC_CTRL_ADDR, d);
    chk("bus_reset", d, 8'h80);
    chk("bus_reset_dflt", {7'h0, dflt}, 8'h01);
    wr(USBGC_CTRL_ADDR, 8'hA0);
    susp = 1;
    repeat (40) @(negedge clk);
    rd(USBGC_CTRL_ADDR, d);
    chk("no_permit", {6'h0, d[3], send}, 8'h00);
    for (int j = 0; j < 2; j++) begin
      dly = j ? 4'hC : 4'h1;
      wr(USBGC_CTRL_ADDR, 8'hA4);
      rd(USBGC_CTRL_ADDR, d);
      chk("status_set", d, 8'hAC);
      for (int k = 0; k < 100 && send !== 1'b1; k++) @(negedge clk);
      chk("send", {7'h0, send}, 8'h01);
      for (int k = 0; k < 50 && send !== 1'b0; k++) @(negedge clk);
      rd(USBGC_CTRL_ADDR, d);
      chk("status_clr", d, 8'hA4);
      // The wake bit is left set past the end of done: no second resume may follow.
      repeat (20) @(negedge clk);
      chk("no_repeat", {7'h0, send}, 8'h00);
      wr(USBGC_CTRL_ADDR, 8'h84);
      repeat (20) @(negedge clk);
    end
    susp = 0;
    close_out;
  end
endmodule // testbench

// file: verif/usbgc_line_model.sv
// Purpose: Line-side partner that ends an upstream resume after a set time.
// Assumes: Changes its output on the falling edge, like the bench stimulus.
// Notes:   Holds done for a while so firmware has time to clear the wake bit.
`timescale 1ns/1ns
module usbgc_line_model (
  input  wire logic       clk,                   // Controller clock
  input  wire logic [3:0] dly,                   // Resume length in cycles
  input  wire logic       resume_send,           // Device signals resume
  output logic            resume_done_in = 1'b0  // Resume signalling finished
);
  logic [3:0] cnt_q  = 4'h0;
  logic [3:0] hold_q = 4'h0;
  always @(negedge clk) begin
    if (resume_send && cnt_q < dly)
      cnt_q <= cnt_q + 4'h1;
    else if (resume_send)
      hold_q <= 4'hF;
    else if (hold_q != 4'h0)
      hold_q <= hold_q - 4'h1;
    else
      cnt_q <= 4'h0;
    resume_done_in <= hold_q != 4'h0;
  end
endmodule // usbgc_line_model

// file: verif/usbgc_monitor.sv
// Purpose: Concurrent checks on the ports of the control register block.
// Assumes: Single clock, synchronous active-low reset.
// Notes:   Attached to every instance of the block by bind.
`timescale 1ns/1ns
module usbgc_monitor
  import usbgc_pkg::*;
#(
  parameter int SUSPEND_CYCLES = USBGC_SUSPEND_CYCLES
) (
  input wire logic       clk,              // Clock
  input wire logic       resetn,           // Reset
  input wire logic [7:0] sfr_addr,         // Address
  input wire logic       sfr_wr,           // Write
  input wire logic       sfr_rd,           // Read
  input wire logic [7:0] sfr_wdata,        // Write data
  input wire logic [7:0] sfr_rdata,        // Read data
  input wire logic       bus_reset_in,     // Bus reset
  input wire logic       bus_suspend_in,   // Bus suspend
  input wire logic       resume_done_in,   // Resume over
  input wire logic       ctrl_reset_n,     // Controller reset
  input wire logic       ctrl_clk_en,      // Clock enable
  input wire logic       wake_request,     // Wake request
  input wire logic       resume_send,      // Resume drive
  input wire logic       use_default_addr, // Address zero
  input wire logic       pullup_out,       // Pull-up value
  input wire logic       pullup_oe         // Pull-up enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic [19:0] susp_q;
  logic [19:0] susp_d;
  logic        wr_hit;
  // Raw suspend time is never shorter than the synchronised one while the raw input stays high.
  always_comb susp_d = (!bus_suspend_in) ? 20'h0 : susp_q + {19'h0, ~&susp_q};
  always_ff @(posedge clk) susp_q <= resetn ? susp_d : 20'h0;
  assign wr_hit = sfr_wr && sfr_addr == USBGC_CTRL_ADDR;
  en_follow_a: assert property (wr_hit |=> ctrl_reset_n == $past(sfr_wdata[7]))
    else $error("controller reset does not follow enable bit");
  clk_gate_a: assert property (wr_hit |=> ctrl_clk_en == ($past(sfr_wdata[7])
    && !$past(sfr_wdata[6]))) else $error("clock enable wrong after write");
  wake_req_a: assert property (wr_hit |=> wake_request == $past(sfr_wdata[5]))
    else $error("wake request does not follow wake bit");
  resume_gate_a: assert property ($rose(resume_send) |-> ctrl_clk_en
    && susp_q >= SUSPEND_CYCLES) else $error("resume sent too early");
  detach_oe_a: assert property (wr_hit |=> pullup_oe == !$past(sfr_wdata[4]))
    else $error("pull-up enable does not follow detach bit");
  pullup_high_a: assert property (sfr_rd && sfr_addr == USBGC_CTRL_ADDR |=>
    sfr_rdata[4] == !$past(pullup_oe) && (!pullup_oe || pullup_out))
    else $error("pull-up drive disagrees with detach bit");
  float_hold_a: assert property (!pullup_oe && !sfr_wr |=> !pullup_oe)
    else $error("pull-up left high impedance unprompted");
  resume_end_a: assert property (resume_done_in [*4] |=> !resume_send)
    else $error("resume continues after done");
  default_addr_a: assert property (bus_reset_in [*4] |=> use_default_addr)
    else $error("bus reset did not clear address valid");
  rd_back_a: assert property (sfr_rd && sfr_addr == USBGC_CTRL_ADDR |=>
    sfr_rdata[7] == $past(ctrl_reset_n) && sfr_rdata[0] == !$past(use_default_addr))
    else $error("read data differs from register state");
  unmapped_rd_a: assert property (sfr_rd && sfr_addr != USBGC_CTRL_ADDR |=>
    sfr_rdata == 8'h00) else $error("unmapped read not zero");
  cover property ($rose(resume_send));
  cover property (bus_reset_in [*4]);
  cover property ($fell(pullup_oe));
endmodule // usbgc_monitor
bind usbgc_ctrl usbgc_monitor #(.SUSPEND_CYCLES(SUSPEND_CYCLES)) mon (
  .clk              (clk),
  .resetn           (resetn),
  .sfr_addr         (sfr_addr),
  .sfr_wr           (sfr_wr),
  .sfr_rd           (sfr_rd),
  .sfr_wdata        (sfr_wdata),
  .sfr_rdata        (sfr_rdata),
  .bus_reset_in     (bus_reset_in),
  .bus_suspend_in   (bus_suspend_in),
  .resume_done_in   (resume_done_in),
  .ctrl_reset_n     (ctrl_reset_n),
  .ctrl_clk_en      (ctrl_clk_en),
  .wake_request     (wake_request),
  .resume_send      (resume_send),
  .use_default_addr (use_default_addr),
  .pullup_out       (pullup_out),
  .pullup_oe        (pullup_oe)
);
